// ---- smbsd_top.sv ----
// SMBus slave command decoder with CSR access port and AHB-Lite status registers.
`timescale 1ns/1ps
`include "smbsd_map.svh"
// How it works
// - Slave address is caught from straps after reset release and held until reset.
// - Address bits 1,2,3,5 come from straps; bit 4 is zero; bits 6,7 one.
// - Byte, word and block reads and writes are all answered.
// - Command bit 0 marks the last transfer; start plus end is one transfer.
// - Command bit 1 marks the first transfer and restarts field pointers.
// - Command bits 4:2 pick function; only CSR access is accepted.
// - Command bits 6:5 give size byte, word or block; reserved is refused.
// - Command bit 7 turns packet error checking on for this transaction.
// - A command during a busy CSR access, or unservable data, is NACKed.
// - Bytes run command, count, control, address low, address high, data.
// - The count never includes the trailing check byte.
// - Address low byte gives the low eight doubleword address bits.
// - Address high byte gives six upper bits; its bits 6 and 7 are ignored.
// - Data bytes carry the word least significant byte first.
// - Control bit 4 chooses CSR write when zero, read when one.
// - Control bits 0 to 3 enable the four data byte lanes.
// - Control bit 6 shows an unclaimed last read, cleared when read.
// - Control bit 7 shows an unclaimed last write, cleared when read.
module smbsd_top
  import smbsd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] slave_addr_strap,
  output logic csr_req,
  output logic csr_write,
  output logic [13:0] csr_addr,
  output logic [31:0] csr_wdata,
  output logic [3:0] csr_be,
  input wire logic csr_done,
  input wire logic csr_claimed,
  input wire logic [31:0] csr_rdata
);
  logic [1:0] bus_s;
  logic [3:0] strap_s;
  logic scl_s, sda_s, scl_d_r, sda_d_r;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [1:0] strap_wait_r;
  logic strap_ok_r;
  logic [6:0] slave_addr_r;
  smbsd_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, tx_r, command_code_byte_r, block_length_byte_r, data_n_r, tx_n_r, crc_r, crc_nxt, crc_byte;
  logic [3:0] rx_idx_r;
  logic rw_r, cc_ok_r, pec_seen_r, pec_ok_r, sda_pend_r, sda_oe_r;
  logic [2:0] wptr_r, rptr_r;
  logic [4:0] hold_cnt_r;
  logic [7:0] fld_r [0:6];
  logic [7:0] rx_lim, tx_lim, tx_nxt;
  logic byte_done, ack_nxt, addr_match, is_cnt, is_data, is_pec, fld_we;
  logic tx_load, tx_fld, cmd_read, nack_ev, launch, pec_bad;
  logic csr_req_r, csr_write_r, rd_unc_r, wr_unc_r;
  logic [13:0] csr_addr_r;
  logic [31:0] csr_wdata_r, hrdata_r, rd_val;
  logic [3:0] csr_be_r;
  logic ctrl_en_r, pec_err_r, ahb_wr_r;
  logic [7:0] ahb_addr_r;
  logic [15:0] nack_cnt_r;

  smbsd_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({scl_in, sda_in}),
    .q(bus_s)
  );

  smbsd_sync #(.W(4), .INIT(4'h0)) u_strap_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(slave_addr_strap),
    .q(strap_s)
  );

  smbsd_crc8 u_crc (
    .crc_in(crc_r),
    .data(crc_byte),
    .crc_out(crc_nxt)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // The straps are sampled once their synchroniser has filled after release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_wait_r <= 2'h0;
      strap_ok_r <= 1'b0;
      slave_addr_r <= 7'h00;
    end else if (!strap_ok_r) begin
      if (strap_wait_r == `SMBSD_STRAP_WAIT) begin
        strap_ok_r <= 1'b1;
        slave_addr_r <= {`SMBSD_ADDR_B76, strap_s[3], `SMBSD_ADDR_B4, strap_s[2:0]};
      end else begin
        strap_wait_r <= strap_wait_r + 2'h1;
      end
    end
  end

  always_comb begin
    case (command_code_byte_r[6:5])
      `SMBSD_SZ_BLOCK: begin
        rx_lim = block_length_byte_r;
        tx_lim = `SMBSD_RD_BLK_CNT + 8'h01;
      end
      `SMBSD_SZ_WORD: begin
        rx_lim = 8'h02;
        tx_lim = 8'h02;
      end
      default: begin
        rx_lim = 8'h01;
        tx_lim = 8'h01;
      end
    endcase
    byte_done = scl_fall && (bit_cnt_r == 4'h8) && (state_r == ST_ADDR || state_r == ST_RX);
    addr_match = strap_ok_r && ctrl_en_r && (shift_r[7:1] == slave_addr_r);
    is_cnt = (rx_idx_r == 4'h1) && (command_code_byte_r[6:5] == `SMBSD_SZ_BLOCK);
    is_data = (rx_idx_r != 4'h0) && !is_cnt && (data_n_r < rx_lim);
    is_pec = (rx_idx_r != 4'h0) && !is_cnt && !is_data;
    ack_nxt = 1'b0;
    if (state_r == ST_ADDR) begin
      ack_nxt = addr_match && (!shift_r[0] || (cc_ok_r && !csr_req_r));
    end else if (rx_idx_r == 4'h0) begin
      ack_nxt = (shift_r[4:2] == `SMBSD_FN_CSR) && (shift_r[6:5] != `SMBSD_SZ_RSVD) && !csr_req_r;
    end else if (is_cnt) begin
      ack_nxt = 1'b1;
    end else if (is_data) begin
      ack_nxt = (wptr_r < `SMBSD_FLD_CNT);
    end else begin
      ack_nxt = command_code_byte_r[`SMBSD_CC_PEC] && !pec_seen_r && (crc_nxt == 8'h00);
    end
    fld_we = byte_done && (state_r == ST_RX) && is_data && (wptr_r < `SMBSD_FLD_CNT);
    pec_bad = byte_done && (state_r == ST_RX) && is_pec && command_code_byte_r[`SMBSD_CC_PEC] && !pec_seen_r && !ack_nxt;
    nack_ev = byte_done && !ack_nxt && (state_r == ST_RX || addr_match);
    tx_load = scl_fall && ((state_r == ST_ACK && rw_r) || state_r == ST_MACK);
    tx_fld = 1'b0;
    cmd_read = 1'b0;
    if (tx_n_r < tx_lim) begin
      if (command_code_byte_r[6:5] == `SMBSD_SZ_BLOCK && tx_n_r == 8'h00) begin
        tx_nxt = `SMBSD_RD_BLK_CNT;
      end else if (rptr_r == 3'h0) begin
        tx_nxt = {wr_unc_r, rd_unc_r, 1'b0, fld_r[0][4:0]};
        tx_fld = 1'b1;
        cmd_read = 1'b1;
      end else if (rptr_r < `SMBSD_FLD_CNT) begin
        tx_nxt = fld_r[rptr_r];
        tx_fld = 1'b1;
      end else begin
        tx_nxt = 8'hFF;
      end
    end else if (tx_n_r == tx_lim && command_code_byte_r[`SMBSD_CC_PEC]) begin
      tx_nxt = crc_r;
    end else begin
      tx_nxt = 8'hFF;
    end
    crc_byte = tx_load ? tx_nxt : shift_r;
    launch = stop_det && !rw_r && cc_ok_r && command_code_byte_r[`SMBSD_CC_END] && !csr_req_r
      && (!command_code_byte_r[`SMBSD_CC_PEC] || pec_ok_r)
      && (fld_r[0][`SMBSD_CTL_DIR] ? (wptr_r >= `SMBSD_FLD_RD_MIN) : (wptr_r == `SMBSD_FLD_CNT));
  end

  // Serial protocol engine: address, receive, acknowledge and transmit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      command_code_byte_r <= 8'h00;
      cc_ok_r <= 1'b0;
      block_length_byte_r <= 8'h00;
      rx_idx_r <= 4'h0;
      data_n_r <= 8'h00;
      tx_n_r <= 8'h00;
      pec_seen_r <= 1'b0;
      pec_ok_r <= 1'b0;
      crc_r <= 8'h00;
      sda_pend_r <= 1'b0;
      wptr_r <= 3'h0;
      rptr_r <= 3'h0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      sda_pend_r <= 1'b0;
      cc_ok_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_pend_r <= 1'b0;
      if (state_r == ST_IDLE) begin
        crc_r <= 8'h00;
        cc_ok_r <= 1'b0;
      end
    end else begin
      case (state_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            crc_r <= crc_nxt;
            sda_pend_r <= ack_nxt;
            state_r <= ack_nxt ? ST_ACK : ST_IDLE;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (state_r == ST_ADDR) begin
              rw_r <= shift_r[0];
              rx_idx_r <= 4'h0;
              data_n_r <= 8'h00;
              tx_n_r <= 8'h00;
              pec_seen_r <= 1'b0;
              pec_ok_r <= 1'b0;
            end else if (rx_idx_r == 4'h0) begin
              command_code_byte_r <= shift_r;
              cc_ok_r <= ack_nxt;
              if (ack_nxt && shift_r[`SMBSD_CC_START]) begin
                wptr_r <= 3'h0;
                rptr_r <= 3'h0;
              end
            end else if (is_cnt) begin
              block_length_byte_r <= shift_r;
            end else if (is_data) begin
              data_n_r <= data_n_r + 8'h01;
              if (fld_we) begin
                wptr_r <= wptr_r + 3'h1;
              end
            end else begin
              pec_seen_r <= 1'b1;
              pec_ok_r <= ack_nxt;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            state_r <= rw_r ? ST_TX : ST_RX;
            sda_pend_r <= 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              tx_n_r <= tx_n_r + 8'h01;
              sda_pend_r <= 1'b0;
              state_r <= ST_MACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_pend_r <= !tx_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s) begin
            state_r <= ST_IDLE;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            state_r <= ST_TX;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      if (tx_load) begin
        tx_r <= tx_nxt;
        crc_r <= crc_nxt;
        sda_pend_r <= !tx_nxt[7];
        if (tx_fld) begin
          rptr_r <= rptr_r + 3'h1;
        end
      end
    end
  end

  // The pin changes only after the data hold time past the falling clock edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_r <= 5'h00;
      sda_oe_r <= 1'b0;
    end else if (start_det || stop_det) begin
      hold_cnt_r <= 5'h00;
      sda_oe_r <= 1'b0;
    end else if (scl_fall) begin
      hold_cnt_r <= 5'(`SMBSD_HOLD_CYC);
    end else if (hold_cnt_r != 5'h00) begin
      hold_cnt_r <= hold_cnt_r - 5'h01;
      if (hold_cnt_r == 5'h01) begin
        sda_oe_r <= sda_pend_r;
      end
    end
  end

  assign sda_oe = sda_oe_r;
  assign sda_out = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 7; i++) begin
        fld_r[i] <= 8'h00;
      end
    end else if (fld_we) begin
      fld_r[wptr_r] <= shift_r;
    end else if (csr_req_r && csr_done && !csr_write_r) begin
      fld_r[3] <= csr_rdata[7:0];
      fld_r[4] <= csr_rdata[15:8];
      fld_r[5] <= csr_rdata[23:16];
      fld_r[6] <= csr_rdata[31:24];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csr_req_r <= 1'b0;
      csr_write_r <= 1'b0;
      csr_addr_r <= 14'h0000;
      csr_be_r <= 4'h0;
      csr_wdata_r <= 32'h00000000;
    end else if (launch) begin
      csr_req_r <= 1'b1;
      csr_write_r <= !fld_r[0][`SMBSD_CTL_DIR];
      csr_addr_r <= {fld_r[2][5:0], fld_r[1]};
      csr_be_r <= fld_r[0][3:0];
      csr_wdata_r <= {fld_r[6], fld_r[5], fld_r[4], fld_r[3]};
    end else if (csr_done) begin
      csr_req_r <= 1'b0;
    end
  end

  assign csr_req = csr_req_r;
  assign csr_write = csr_write_r;
  assign csr_addr = csr_addr_r;
  assign csr_be = csr_be_r;
  assign csr_wdata = csr_wdata_r;

  // A completion updating a flag wins over the clear by the control byte read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_unc_r <= 1'b0;
      wr_unc_r <= 1'b0;
    end else begin
      if (csr_req_r && csr_done && !csr_write_r) begin
        rd_unc_r <= !csr_claimed;
      end else if (tx_load && cmd_read) begin
        rd_unc_r <= 1'b0;
      end
      if (csr_req_r && csr_done && csr_write_r) begin
        wr_unc_r <= !csr_claimed;
      end else if (tx_load && cmd_read) begin
        wr_unc_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (haddr[7:0])
      `SMBSD_REG_CTRL: rd_val = {31'h0, ctrl_en_r};
      `SMBSD_REG_STATUS: rd_val = {20'h0, pec_err_r, wr_unc_r, rd_unc_r, csr_req_r, strap_ok_r, slave_addr_r};
      `SMBSD_REG_NACKS: rd_val = {16'h0, nack_cnt_r};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Zero-wait AHB-Lite slave; unmapped words read zero and ignore writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_r <= 1'b0;
      ahb_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      ahb_wr_r <= hsel && htrans[1] && hready && hwrite;
      ahb_addr_r <= haddr[7:0];
      hrdata_r <= (hsel && htrans[1] && hready && !hwrite) ? rd_val : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_r <= `SMBSD_CTRL_RST;
      pec_err_r <= 1'b0;
      nack_cnt_r <= 16'h0000;
    end else begin
      if (ahb_wr_r && ahb_addr_r == `SMBSD_REG_CTRL) begin
        ctrl_en_r <= hwdata[0];
      end
      if (pec_bad) begin
        pec_err_r <= 1'b1;
      end else if (ahb_wr_r && ahb_addr_r == `SMBSD_REG_STATUS && hwdata[`SMBSD_STS_PEC_ERR]) begin
        pec_err_r <= 1'b0;
      end
      if (nack_ev) begin
        nack_cnt_r <= nack_cnt_r + 16'h0001;
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule : smbsd_top

// ---- smbsd_map.svh ----
// Offsets, field positions, reset values and timing counts of the SMBus slave command decoder.
`ifndef SMBSD_MAP_SVH
`define SMBSD_MAP_SVH
`define SMBSD_CLK_MHZ 40
`define SMBSD_HOLD_NS 300
`define SMBSD_HOLD_CYC ((`SMBSD_HOLD_NS * `SMBSD_CLK_MHZ + 999) / 1000)
`define SMBSD_ADDR_B76 2'h3
`define SMBSD_ADDR_B4 1'h0
`define SMBSD_STRAP_WAIT 2'h2
`define SMBSD_CC_END 0
`define SMBSD_CC_START 1
`define SMBSD_CC_PEC 7
`define SMBSD_FN_CSR 3'h0
`define SMBSD_SZ_WORD 2'h1
`define SMBSD_SZ_BLOCK 2'h2
`define SMBSD_SZ_RSVD 2'h3
`define SMBSD_CTL_DIR 4
`define SMBSD_FLD_CNT 3'h7
`define SMBSD_FLD_RD_MIN 3'h3
`define SMBSD_RD_BLK_CNT 8'h07
`define SMBSD_CRC_POLY 8'h07
`define SMBSD_REG_CTRL 8'h00
`define SMBSD_REG_STATUS 8'h04
`define SMBSD_REG_NACKS 8'h08
`define SMBSD_CTRL_RST 1'h1
`define SMBSD_STS_PEC_ERR 11
`endif

// ---- smbsd_pkg.sv ----
// Types shared by the SMBus slave command decoder.
package smbsd_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_MACK} smbsd_state_e;
endpackage : smbsd_pkg

// ---- smbsd_sync.sv ----
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module smbsd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : smbsd_sync

// ---- smbsd_crc8.sv ----
// One-byte step of the SMBus packet error checking CRC-8.
`timescale 1ns/1ps
`include "smbsd_map.svh"
module smbsd_crc8 (
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data,
  output logic [7:0] crc_out
);
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `SMBSD_CRC_POLY) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end
endmodule : smbsd_crc8

// ---- smbsd_assertions.sv ----
// Port checker of the SMBus slave command decoder, bound into its top module.
`timescale 1ns/1ps
`include "smbsd_map.svh"
module smbsd_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic csr_req,
  input wire logic csr_write,
  input wire logic [13:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  input wire logic [3:0] csr_be,
  input wire logic csr_done
);
  logic scl_d_r;
  logic sda_d_r;
  logic [7:0] fall_cnt_r;
  logic [7:0] stop_cnt_r;
  // Cycles since the clock pin fell and since the last stop condition.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      fall_cnt_r <= 8'hFF;
      stop_cnt_r <= 8'hFF;
    end else begin
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
      fall_cnt_r <= (scl_d_r && !scl_in) ? 8'h00 : fall_cnt_r + {7'h00, fall_cnt_r != 8'hFF};
      stop_cnt_r <= (scl_d_r && scl_in && sda_in && !sda_d_r) ? 8'h00 : stop_cnt_r + {7'h00, stop_cnt_r != 8'hFF};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_live;
    csr_req && !csr_done;
  endsequence
  sequence s_status_rd;
    hsel && htrans[1] && hready && !hwrite && haddr == {24'h0, `SMBSD_REG_STATUS};
  endsequence
  property p_req_hold;
    s_live |=> csr_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before done");
  property p_req_end;
    csr_req && csr_done |=> !csr_req;
  endproperty
  a_req_end: assert property (p_req_end) else $error("request kept after done");
  property p_req_stable;
    s_live |=> $stable({csr_write, csr_addr, csr_wdata, csr_be});
  endproperty
  a_req_stable: assert property (p_req_stable) else $error("request fields moved");
  property p_launch;
    $rose(csr_req) |-> stop_cnt_r inside {[8'h01:8'h08]};
  endproperty
  a_launch: assert property (p_launch) else $error("request not launched by a stop");
  property p_oe_low;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("data moved with clock high");
  property p_oe_delay;
    $changed(sda_oe) |-> fall_cnt_r inside {[8'h0A:8'h16]};
  endproperty
  a_oe_delay: assert property (p_oe_delay) else $error("data not held after clock fall");
  property p_status_addr;
    s_status_rd |=> !hrdata[7] || (hrdata[6:5] == 2'h3 && !hrdata[3]);
  endproperty
  a_status_addr: assert property (p_status_addr) else $error("fixed address bits wrong");
  property p_rd_idle;
    !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
  property p_reset_quiet;
    $rose(hresetn) |-> !csr_req && !sda_oe && hrdata == 32'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule : smbsd_assertions

bind smbsd_top smbsd_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hrdata, .hresp, .scl_in, .sda_in, .sda_oe, .csr_req, .csr_write, .csr_addr, .csr_wdata, .csr_be, .csr_done);

// ---- smbsd_master_model.sv ----
// SMBus master model driving the clock pin and the open-drain data pin.
`timescale 1ns/1ps
`include "smbsd_map.svh"
module smbsd_master_model #(
  parameter int HALF = 16
) (
  input wire logic hclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  logic [7:0] crc;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    crc = 8'h00;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : wait_cyc
  // Packet check byte over every byte on the bus since the start from idle.
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ `SMBSD_CRC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction : crc_step
  task automatic start_cond();
    sda <= 1'b1;
    wait_cyc(HALF);
    scl <= 1'b1;
    wait_cyc(HALF);
    sda <= 1'b0;
    wait_cyc(HALF);
    scl <= 1'b0;
    wait_cyc(4);
  endtask : start_cond
  task automatic stop_cond();
    sda <= 1'b0;
    wait_cyc(HALF);
    scl <= 1'b1;
    wait_cyc(HALF);
    sda <= 1'b1;
    wait_cyc(HALF);
  endtask : stop_cond
  // Data changes only while the clock is low; the released line floats high.
  task automatic one_bit(input logic b, output logic r);
    sda <= b;
    wait_cyc(HALF);
    scl <= 1'b1;
    wait_cyc(HALF / 2);
    r = sda_line;
    wait_cyc(HALF / 2);
    scl <= 1'b0;
    wait_cyc(4);
  endtask : one_bit
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      one_bit(d[i], r);
    end
    one_bit(1'b1, r);
    ack = !r;
    crc = crc_step(crc, d);
  endtask : wr_byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      one_bit(1'b1, d[i]);
    end
    one_bit(last, r);
    crc = crc_step(crc, d);
  endtask : rd_byte
endmodule : smbsd_master_model

// ---- tb.sv ----
// Self-checking testbench of the SMBus slave command decoder.
`timescale 1ns/1ps
`include "smbsd_map.svh"
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, sda_out, sda_oe, csr_req, csr_write, scl, msda;
  logic [31:0] hrdata, csr_wdata, sw;
  logic [13:0] csr_addr;
  logic [3:0] csr_be;
  logic [18:0] sc;
  logic [3:0] strap = 4'h0;
  logic csr_done = 1'b0;
  logic csr_claimed = 1'b0;
  logic hold = 1'b0;
  logic [31:0] csr_rdata = 32'h0;
  logic [31:0] rnd = 32'hE7591930;
  int errors = 0;
  int num_checks = 0;
  int n_csr = 0;
  wire sda_line = msda & !(sda_oe && !sda_out);
  always #12.5 hclk = ~hclk;
  smbsd_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .slave_addr_strap(strap),
    .csr_req, .csr_write, .csr_addr, .csr_wdata, .csr_be, .csr_done, .csr_claimed, .csr_rdata);
  smbsd_master_model m (.hclk, .sda_line, .scl, .sda(msda));
  // Register side: answers each request unless held off.
  always @(posedge hclk) begin
    csr_done <= csr_req && !csr_done && !hold;
    if (csr_req && !csr_done && !hold) begin
      sc <= {csr_write, csr_addr, csr_be};
      sw <= csr_wdata;
      n_csr <= n_csr + 1;
    end
  end
  function automatic logic [31:0] nx();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction : nx
  function automatic logic [7:0] aw(input logic [3:0] s, input logic rw);
    return {2'h3, s[3], 1'h0, s[2:0], rw};
  endfunction : aw
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  // Sends one write transfer; the byte at index nak is expected to be refused.
  task automatic send(input logic [7:0] b[$], input int nak, input logic pec, input logic [7:0] flip);
    logic ack;
    m.crc = 8'h00;
    m.start_cond();
    foreach (b[i]) begin
      if (i <= nak) begin
        m.wr_byte(b[i], ack);
        check("ack", {31'h0, ack}, {31'h0, i != nak});
      end
    end
    if (pec && nak >= b.size()) begin
      m.wr_byte(m.crc ^ flip, ack);
      check("pec ack", {31'h0, ack}, {31'h0, flip == 8'h00});
    end
    m.stop_cond();
  endtask : send
  task automatic wait_csr(input int n);
    for (int k = 0; k < 400 && n_csr != n; k++) @(posedge hclk);
    check("csr count", n_csr, n);
  endtask : wait_csr
  initial begin
    repeat (80000) @(posedge hclk);
    errors++;
    test_done();
  end
  initial begin
    logic [31:0] rd, wd;
    logic [7:0] ax, ar, al, ah, be, x, p;
    logic [7:0] e[$];
    logic ak;
    strap <= rnd[3:0];
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    ax = aw(strap, 1'b0);
    ar = aw(strap, 1'b1);
    ahb(1'b0, `SMBSD_REG_STATUS, 32'h0, rd);
    check("status", rd, {24'h0, 1'b1, ax[7:1]});
    ahb(1'b0, `SMBSD_REG_CTRL, 32'h0, rd);
    check("ctrl", rd, 32'h1);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    // Word and byte transfers fill the fields of one write sequence.
    x = nx();
    be = {4'h0, rnd[3:0]};
    al = rnd[15:8];
    ah = {2'h0, rnd[21:16]};
    wd = nx();
    csr_claimed <= 1'b1;
    send({ax, 8'h22, be, al}, 99, 1'b0, 8'h00);
    send({ax, 8'h20, ah, wd[7:0]}, 99, 1'b0, 8'h00);
    send({ax, 8'h20, wd[15:8], wd[23:16]}, 99, 1'b0, 8'h00);
    check("early launch", n_csr, 0);
    send({ax, 8'h01, wd[31:24]}, 99, 1'b0, 8'h00);
    wait_csr(1);
    check("csr ctl", {13'h0, sc}, {13'h0, 1'b1, ah[5:0], al, be[3:0]});
    check("csr data", sw, wd);
    // Block write with checking; other commands are refused while it is busy.
    x = nx();
    be = {4'h0, rnd[3:0]};
    al = rnd[15:8];
    ah = {2'h0, rnd[21:16]};
    wd = nx();
    hold <= 1'b1;
    csr_claimed <= 1'b0;
    send({ax, 8'hC3, 8'h07, be, al, ah, wd[7:0], wd[15:8], wd[23:16], wd[31:24]}, 99, 1'b1, 8'h00);
    check("launch", {31'h0, csr_req}, 32'h1);
    send({ax, 8'h43}, 1, 1'b0, 8'h00);
    send({ar}, 0, 1'b0, 8'h00);
    hold <= 1'b0;
    wait_csr(2);
    check("csr ctl", {13'h0, sc}, {13'h0, 1'b1, ah[5:0], al, be[3:0]});
    check("csr data", sw, wd);
    ahb(1'b0, `SMBSD_REG_STATUS, 32'h0, rd);
    check("status", rd, {21'h0, 3'h4, 1'b1, ax[7:1]});
    // Read setup, then a block read of the fields back.
    x = nx();
    be = {4'h1, rnd[3:0]};
    al = rnd[15:8];
    ah = {2'h0, rnd[21:16]};
    csr_rdata <= nx();
    csr_claimed <= 1'b1;
    send({ax, 8'hC3, 8'h03, be, al, ah}, 99, 1'b1, 8'h00);
    wait_csr(3);
    check("csr ctl", {13'h0, sc}, {13'h0, 1'b0, ah[5:0], al, be[3:0]});
    m.crc = 8'h00;
    m.start_cond();
    m.wr_byte(ax, ak);
    m.wr_byte(8'hC3, ak);
    m.start_cond();
    m.wr_byte(ar, ak);
    check("read ack", {31'h0, ak}, 32'h1);
    e = {8'h07, 8'h80 | be, al, ah, rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24]};
    foreach (e[i]) begin
      m.rd_byte(1'b0, x);
      check("read byte", {24'h0, x}, {24'h0, e[i]});
    end
    p = m.crc;
    m.rd_byte(1'b1, x);
    check("read pec", {24'h0, x}, {24'h0, p});
    m.stop_cond();
    ahb(1'b0, `SMBSD_REG_STATUS, 32'h0, rd);
    check("status", rd, {24'h0, 1'b1, ax[7:1]});
    // Reserved codes, a bad check byte and a disabled slave are refused.
    e = {8'h07, 8'h0B, 8'h1F, 8'h63};
    foreach (e[i]) begin
      send({ax, e[i]}, 1, 1'b0, 8'h00);
    end
    send({ax, 8'hC3, 8'h03, 8'h10, al, ah}, 99, 1'b1, 8'h01);
    ahb(1'b0, `SMBSD_REG_STATUS, 32'h0, rd);
    check("status", rd, {20'h0, 4'h8, 1'b1, ax[7:1]});
    ahb(1'b1, `SMBSD_REG_STATUS, 32'h800, rd);
    ahb(1'b0, `SMBSD_REG_STATUS, 32'h0, rd);
    check("status", rd, {24'h0, 1'b1, ax[7:1]});
    ahb(1'b0, `SMBSD_REG_NACKS, 32'h0, rd);
    check("nacks", rd, 32'h7);
    ahb(1'b1, `SMBSD_REG_CTRL, 32'h0, rd);
    send({ax}, 0, 1'b0, 8'h00);
    ahb(1'b1, `SMBSD_REG_CTRL, 32'h1, rd);
    // The address stays until the next reset picks up the new straps.
    strap <= ~strap;
    repeat (4) @(posedge hclk);
    ahb(1'b0, `SMBSD_REG_STATUS, 32'h0, rd);
    check("status", rd, {24'h0, 1'b1, ax[7:1]});
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    ax = aw(strap, 1'b0);
    ahb(1'b0, `SMBSD_REG_STATUS, 32'h0, rd);
    check("status", rd, {24'h0, 1'b1, ax[7:1]});
    test_done();
  end
endmodule : tb
